// ==== include/mac_map.svh ====
// Register offsets, field positions, reset values and counts of the monitor converter control
`ifndef MAC_MAP_SVH
`define MAC_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define MAC_CONVERTER_CONTROL_OFS 8'hE4
`define MAC_RESULT_BASE_OFS       8'hD0
`define MAC_RESULT_LAST_OFS       8'hDB

// ----------------------------------------------------------------------
// Converter control fields
// ----------------------------------------------------------------------
`define MAC_HALT_BIT              0
`define MAC_CHAN_LSB              1
`define MAC_CHAN_MSB              3
`define MAC_ALERT_EN_BIT          4
`define MAC_BUSY_BIT              5

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define MAC_HALT_RESET            1'h0
`define MAC_ALERT_EN_RESET        1'h0
`define MAC_CHAN_RESET            3'h0
`define MAC_NUM_CHANNELS          6
`define MAC_RESULT_WIDTH          10

`endif

// ==== include/mac_pkg.sv ====
// Types shared by the monitor converter control logic
package mac_pkg;

  // ----------------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CH_SOURCE_VOLTAGE_ONE = 3'h0,
    CH_SOURCE_VOLTAGE_TWO = 3'h1,
    CH_AUX_INPUT_ONE      = 3'h2,
    CH_AUX_INPUT_TWO      = 3'h3,
    CH_SENSE_CURRENT_ONE  = 3'h4,
    CH_SENSE_CURRENT_TWO  = 3'h5
  } mac_chan_e;

  // ----------------------------------------------------------------------
  // Register access from the management bus engine
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } mac_req_s;

  // ----------------------------------------------------------------------
  // Converter core request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       start;
    logic [2:0] chan;
  } mac_conv_s;

endpackage : mac_pkg

// ==== verilog/mac_ctrl.sv ====
// Conversion control, busy status, alert pull-down and result bytes of the monitor converter
//
// Summary of operation
// - Busy status reads at bit five, read-only
// - Busy high free-running or single shot queued/running; low otherwise
// - Alert enable pulls alert low after measurement
// - Halted channel write of a code 000-101 starts exactly one measurement
// - Codes 000-101 pick sources, aux, sense currents
// - Stop bit halts converter; clearing resumes free-run
// - Result split: high byte 9..2, low top
`timescale 1ns/10ps
`include "mac_map.svh"

module mac_ctrl
  import mac_pkg::*;
#(
  parameter int NUM_CH = `MAC_NUM_CHANNELS,
  parameter int RES_W  = `MAC_RESULT_WIDTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Register access from the management bus engine
  input  wire mac_req_s         reg_req,
  output logic [7:0]            reg_rdata,
  // Converter core
  output mac_conv_s             conv,
  input  wire logic             conv_done,
  input  wire logic [RES_W-1:0] conv_result,
  // Open-drain alert pin
  output logic                  alert_o,
  output logic                  alert_oe
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SHOT, ST_DRAIN} mac_state_e;

  mac_state_e state_reg;
  logic       halt_reg;
  logic       alert_en_reg;
  logic [2:0] chan_reg;
  logic       shot_pend_reg;
  logic       alert_pend_reg;
  logic [2:0] rr_reg;
  logic [2:0] cur_ch_reg;
  logic [7:0] res_hi_reg [NUM_CH];
  logic [1:0] res_lo_reg [NUM_CH];
  logic       busy;
  logic       ctrl_wr;
  logic       res_wr;
  logic [3:0] res_idx;
  logic       store;
  logic       shot_req;
  logic       shot_take;

  // Valid codes stop at the second sense current
  function automatic logic chan_ok(input logic [2:0] c);
    return c <= 3'(CH_SENSE_CURRENT_TWO);
  endfunction : chan_ok

  // Result bytes sit in one window, two per channel
  function automatic logic res_hit(input logic [7:0] a);
    return (a >= `MAC_RESULT_BASE_OFS) && (a <= `MAC_RESULT_LAST_OFS);
  endfunction : res_hit

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign ctrl_wr = reg_req.wr && (reg_req.addr == `MAC_CONVERTER_CONTROL_OFS);
  assign res_idx = 4'(reg_req.addr - `MAC_RESULT_BASE_OFS);
  assign res_wr  = reg_req.wr && halt_reg && res_hit(reg_req.addr);
  assign store   = conv_done && ((state_reg == ST_RUN) || (state_reg == ST_SHOT));
  // A write that sets stop from free-run idle only halts; the free-run start launched on that edge is drained in ST_DRAIN
  assign shot_req  = ctrl_wr && reg_req.wdata[`MAC_HALT_BIT]
                     && chan_ok(reg_req.wdata[`MAC_CHAN_MSB:`MAC_CHAN_LSB])
                     && (halt_reg || (state_reg != ST_IDLE));
  assign shot_take = (state_reg == ST_IDLE) && halt_reg && shot_pend_reg;

  // ----------------------------------------------------------------------
  // Busy status
  // ----------------------------------------------------------------------
  // A queued single shot counts as converting so software never sees a gap
  assign busy = !halt_reg || (state_reg == ST_SHOT) || shot_pend_reg;

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_reg     <= `MAC_HALT_RESET;
      alert_en_reg <= `MAC_ALERT_EN_RESET;
      chan_reg     <= `MAC_CHAN_RESET;
    end else if (ctrl_wr) begin
      halt_reg     <= reg_req.wdata[`MAC_HALT_BIT];
      alert_en_reg <= reg_req.wdata[`MAC_ALERT_EN_BIT];
      chan_reg     <= reg_req.wdata[`MAC_CHAN_MSB:`MAC_CHAN_LSB];
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg     <= ST_IDLE;
      rr_reg        <= 3'h0;
      cur_ch_reg    <= 3'h0;
      conv          <= '0;
    end else begin
      conv.start <= 1'h0;
      case (state_reg)
        ST_IDLE: begin
          // Rotation resumes where it stopped, so a halt never starves a channel
          if (!halt_reg) begin
            conv.start <= 1'h1;
            conv.chan  <= rr_reg;
            cur_ch_reg <= rr_reg;
            rr_reg     <= (rr_reg == 3'(NUM_CH - 1)) ? 3'h0 : 3'(rr_reg + 3'h1);
            state_reg  <= ST_RUN;
          end else if (shot_pend_reg) begin
            conv.start    <= 1'h1;
            conv.chan     <= chan_reg;
            cur_ch_reg    <= chan_reg;
            state_reg     <= ST_SHOT;
          end
        end
        ST_RUN: begin
          // Halting mid-conversion waits in ST_DRAIN for the done pulse and throws the result away
          if (halt_reg) begin
            state_reg <= conv_done ? ST_IDLE : ST_DRAIN;
          end else if (conv_done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SHOT: begin
          if (conv_done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_DRAIN: begin
          if (conv_done) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Single-shot queue
  // ----------------------------------------------------------------------
  // A new request in the cycle the old one launches wins, so no write is lost
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shot_pend_reg <= 1'h0;
    end else if (shot_req) begin
      shot_pend_reg <= 1'h1;
    end else if (shot_take) begin
      shot_pend_reg <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Result bytes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_CH; i++) begin
        res_hi_reg[i] <= 8'h00;
        res_lo_reg[i] <= 2'h0;
      end
    end else if (store && !(state_reg == ST_RUN && halt_reg)) begin
      res_hi_reg[cur_ch_reg] <= conv_result[RES_W-1:RES_W-8];
      res_lo_reg[cur_ch_reg] <= conv_result[1:0];
    end else if (res_wr) begin
      // Results are writable only while halted; a single-shot store in the same cycle wins over the write
      if (res_idx[0]) begin
        res_lo_reg[res_idx[3:1]] <= reg_req.wdata[7:6];
      end else begin
        res_hi_reg[res_idx[3:1]] <= reg_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Alert pull-down
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_pend_reg <= 1'h0;
    end else if (store && alert_en_reg) begin
      alert_pend_reg <= 1'h1;
    end else if (ctrl_wr || !alert_en_reg) begin
      alert_pend_reg <= 1'h0;
    end
  end

  // Open-drain pin: data held low, the enable alone pulls the line
  assign alert_o  = 1'h0;
  assign alert_oe = alert_pend_reg;

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.addr == `MAC_CONVERTER_CONTROL_OFS) begin
      reg_rdata <= {2'h0, busy, alert_en_reg, chan_reg, halt_reg};
    end else if (res_hit(reg_req.addr)) begin
      // Odd offsets are the low byte; its tail reads as zero
      reg_rdata <= res_idx[0] ? {res_lo_reg[res_idx[3:1]], 6'h00}
                              : res_hi_reg[res_idx[3:1]];
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : mac_ctrl

// ==== verif/mac_ctrl_monitor.sv ====
// Concurrent checks on the converter control ports
`timescale 1ns/10ps
`include "mac_map.svh"
module mac_ctrl_monitor
  import mac_pkg::*;
#(
  parameter int NUM_CH = 6,
  parameter int RES_W  = 10
) (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rst_b,
  // Watched ports
  input wire mac_req_s         reg_req,
  input wire logic [7:0]       reg_rdata,
  input wire mac_conv_s        conv,
  input wire logic             conv_done,
  input wire logic [RES_W-1:0] conv_result,
  input wire logic             alert_o,
  input wire logic             alert_oe
);
  localparam logic [7:0] CTL = `MAC_CONVERTER_CONTROL_OFS;
  logic       halt_q;
  logic       halt_d;
  logic       ae_q;
  logic       fr_v;
  logic [2:0] fr_last;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_q <= 1'b0;
      ae_q <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == CTL) begin
      halt_q <= reg_req.wdata[0];
      ae_q <= reg_req.wdata[4];
    end
  end
  // Rotation is only judged between two free-run starts; a halt forgets it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_d <= 1'b0;
      fr_v <= 1'b0;
      fr_last <= 3'h0;
    end else begin
      halt_d <= halt_q;
      if (halt_q || halt_d) begin
        fr_v <= 1'b0;
      end else if (conv.start) begin
        fr_v <= 1'b1;
        fr_last <= conv.chan;
      end
    end
  end
  AST_ALERT_DATA: assert property (alert_o == 1'b0)
    else $error("alert data not low");
  AST_START_PULSE: assert property (conv.start |=> !conv.start)
    else $error("start longer than one cycle");
  AST_ALERT_CAUSE: assert property ($rose(alert_oe) |-> $past(conv_done) && $past(ae_q))
    else $error("alert without enabled completion");
  AST_ALERT_CLEAR: assert property (reg_req.wr && reg_req.addr == CTL && !conv_done |=> !alert_oe)
    else $error("alert kept after control write");
  AST_CTL_RSVD: assert property ($past(reg_req.addr) == CTL |-> reg_rdata[7:6] == 2'h0)
    else $error("control top bits not zero");
  AST_LOW_BYTE: assert property ($past(reg_req.addr[7:4]) == 4'hD && $past(reg_req.addr[3:0]) < 4'hC
      && $past(reg_req.addr[0]) |-> reg_rdata[5:0] == 6'h00)
    else $error("result low byte tail not zero");
  AST_BUSY_FREE: assert property (!halt_q && !$past(halt_q) && $past(reg_req.addr) == CTL
      |-> reg_rdata[5])
    else $error("busy low in free run");
  AST_ROTATE: assert property (conv.start && !halt_q && fr_v
      |-> conv.chan == (fr_last == 3'h5 ? 3'h0 : fr_last + 3'h1))
    else $error("free run order broken");
  cover property (conv.start && halt_q);
  cover property ($rose(alert_oe));
  cover property (conv.start && !halt_q && conv.chan == 3'h5);
endmodule : mac_ctrl_monitor

// ==== verif/mac_core_model.sv ====
// Behavioural converter core answering each start with one done pulse
`timescale 1ns/10ps
module mac_core_model
  import mac_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Converter link
  input wire mac_conv_s   conv,
  output logic            conv_done,
  output logic [9:0]      conv_result
);
  logic [2:0] wait_cnt;
  logic       busy;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      wait_cnt <= 3'h0;
      conv_done <= 1'b0;
      conv_result <= 10'h155;
    end else begin
      conv_done <= 1'b0;
      // Result toggles outside the done cycle so stale data never matches
      conv_result <= ~conv_result;
      if (conv.start) begin
        busy <= 1'b1;
        wait_cnt <= 3'($urandom_range(4, 0));
      end else if (busy && wait_cnt == 3'h0) begin
        busy <= 1'b0;
        conv_done <= 1'b1;
        conv_result <= {conv.chan, 7'h2B};
      end else if (busy) begin
        wait_cnt <= wait_cnt - 3'h1;
      end
    end
  end
endmodule : mac_core_model

// ==== verif/mac_ctrl_test.sv ====
// Self-checking bench for the monitor converter control
`timescale 1ns/10ps
`include "mac_map.svh"
module mac_ctrl_test;
  import mac_pkg::*;
  localparam logic [7:0] CTL = `MAC_CONVERTER_CONTROL_OFS;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  mac_req_s   reg_req = '0;
  logic [7:0] reg_rdata, rd, base;
  mac_conv_s  conv;
  logic       conv_done, alert_o, alert_oe, ae;
  logic [9:0] conv_result;
  logic [2:0] c;
  int         n_errors = 0, num_checks = 0, n_start = 0, s0;
  always #5 clk = ~clk;
  always @(posedge clk) if (conv.start === 1'b1) n_start++;
  mac_ctrl dut (.clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv(conv), .conv_done(conv_done), .conv_result(conv_result), .alert_o(alert_o),
    .alert_oe(alert_oe));
  mac_core_model core (.clk(clk), .rst_b(rst_b), .conv(conv), .conv_done(conv_done),
    .conv_result(conv_result));
  function automatic logic [9:0] res_of(input logic [2:0] ch);
    return {ch, 7'h2B};
  endfunction : res_of
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{addr: a, wr: 1'b1, wdata: d};
    @(posedge clk) reg_req.wr <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge clk) reg_req.addr <= a;
    @(posedge clk);
    #1 rd = reg_rdata;
  endtask : rdr
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // Bounded poll of the busy flag
  task automatic wait_idle;
    for (int k = 0; k < 40; k++) begin
      rdr(CTL);
      if (rd[5] === 1'b0) return;
    end
    n_errors++;
    tally_and_finish();
  endtask : wait_idle
  task automatic check_result(input logic [2:0] ch);
    rdr(8'hD0 + {4'h0, ch, 1'b0});
    check(rd, res_of(ch)[9:2]);
    rdr(8'hD1 + {4'h0, ch, 1'b0});
    check(rd, {res_of(ch)[1:0], 6'h00});
  endtask : check_result
  initial begin
    void'($urandom(32'hCE439EC1));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rdr(CTL);
    check(rd, 8'h20);
    repeat (80) @(posedge clk);
    for (int i = 0; i < 6; i++) check_result(3'(i));
    rdr(8'h10);
    check(rd, 8'h00);
    wr(CTL, 8'h01);
    wait_idle();
    for (int i = 0; i < 10; i++) begin
      c = (i < 6) ? 3'(i) : 3'($urandom_range(5, 0));
      ae = 1'($urandom);
      base = 8'hD0 + {4'h0, c, 1'b0};
      wr(base, 8'h00);
      wr(base + 8'h01, 8'h00);
      s0 = n_start;
      wr(CTL, {3'h0, ae, c, 1'b1});
      wait_idle();
      check(rd, {3'h0, ae, c, 1'b1});
      check(8'(n_start - s0), 8'h01);
      check({7'h00, alert_oe}, {7'h00, ae});
      check({7'h00, alert_o}, 8'h00);
      check_result(c);
    end
    // Code 110 is outside the table and must start nothing
    s0 = n_start;
    wr(CTL, 8'h0D);
    repeat (10) @(posedge clk);
    check(8'(n_start - s0), 8'h00);
    rdr(CTL);
    check(rd, 8'h0D);
    check({7'h00, alert_oe}, 8'h00);
    wr(CTL, 8'h00);
    rdr(CTL);
    check(rd, 8'h20);
    s0 = n_start;
    repeat (20) @(posedge clk);
    check({7'h00, n_start > s0}, 8'h01);
    tally_and_finish();
  end
endmodule : mac_ctrl_test
bind mac_ctrl mac_ctrl_monitor #(.NUM_CH(NUM_CH), .RES_W(RES_W)) mon (.clk(clk), .rst_b(rst_b),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .conv(conv), .conv_done(conv_done),
  .conv_result(conv_result), .alert_o(alert_o), .alert_oe(alert_oe));
